/* include/fhc_pkg.sv */
// Package for the parallel NOR flash host controller.
// Assumes a 40 MHz system clock; flash data and ready pins are asynchronous to it.
package fhc_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 22;  // Word address width
  localparam int DATA_W = 16;  // Word data width

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 25_000;  // 40 MHz period
  localparam int RSP_US = 4;  // High voltage setup before writes
  localparam int RRB_US = 4;  // High voltage hold after ready
  localparam int RSP_CYC = (RSP_US * 1_000_000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RRB_CYC = (RRB_US * 1_000_000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WE_LOW_CYC = 2;  // Strobe low phase, 50 ns
  localparam int WE_HIGH_CYC = 2;  // Strobe high phase, 50 ns
  localparam int RD_CYC = 4;  // Output enable low phase, 100 ns
  localparam int RD_GAP_CYC = 2;  // Output enable high between polls
  localparam int CNT_W = 16;  // Timer width

  // ----------------------------------------------------------------
  // Command codes and unlock addresses
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR1 = 22'h00_0555;
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR2 = 22'h00_02AA;
  localparam logic [DATA_W-1:0] UNLOCK_DATA1 = 16'h00AA;
  localparam logic [DATA_W-1:0] UNLOCK_DATA2 = 16'h0055;
  localparam logic [DATA_W-1:0] CMD_PROGRAM = 16'h00A0;
  localparam logic [DATA_W-1:0] CMD_ERASE_SETUP = 16'h0080;
  localparam logic [DATA_W-1:0] CMD_SECTOR_ERASE = 16'h0030;
  localparam logic [DATA_W-1:0] CMD_PROTECT = 16'h0060;

  // ----------------------------------------------------------------
  // Status bit positions
  // ----------------------------------------------------------------
  localparam int POLLING_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int SUSPEND_TOGGLE_BIT = 2;

  // ----------------------------------------------------------------
  // Protect address bits
  // ----------------------------------------------------------------
  localparam int ADDR_BIT_SIX = 6;
  localparam int ADDR_BIT_ONE = 1;
  localparam int ADDR_BIT_ZERO = 0;

  // ----------------------------------------------------------------
  // User operations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    FHC_OP_READ = 3'h0,
    FHC_OP_PROGRAM = 3'h1,
    FHC_OP_ERASE = 3'h2,
    FHC_OP_PROTECT = 3'h3,
    FHC_OP_UNPROTECT = 3'h4
  } fhc_op_e;

  // User request
  typedef struct packed {
    fhc_op_e op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic bypass;  // Unlock bypass active
    logic temp_unprotect;  // Wrap in high voltage window
  } fhc_req_s;

  // Flash pin group driven by host
  typedef struct packed {
    logic chip_select_n;
    logic output_drive_n;
    logic write_strobe_n;
    logic restart_n;
    logic high_voltage_en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dout;
    logic dout_en;
  } fhc_pins_s;
endpackage : fhc_pkg

/* rtl/fhc_sync.sv */
// Two flip-flop synchroniser, W bits wide in one instance.
// Assumes the input is asynchronous to clk.
`timescale 1ns/100ps
module fhc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;  // First stage, read only by second
  // ----------------------------------------------------------------
  // Two stages
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule : fhc_sync

/* rtl/fhc_host.sv */
// Host controller driving a parallel NOR flash through its pins.
// Assumes a 40 MHz clk; flash data and ready pins are asynchronous.
`timescale 1ns/100ps
module fhc_host
  import fhc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire fhc_req_s req,
  output logic req_ready,
  output logic done,
  output logic [DATA_W-1:0] rdata,
  output logic toggle_error,
  output fhc_pins_s pins,
  input wire logic [DATA_W-1:0] flash_din,
  input wire logic ready_busy_n
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] din_s;  // Synchronised data bus
  logic rdy_s;  // Synchronised ready
  fhc_sync #(.W(DATA_W)) u_din (.clk(clk), .rst(rst), .d(flash_din), .q(din_s));
  fhc_sync #(.W(1)) u_rdy (.clk(clk), .rst(rst), .d(ready_busy_n), .q(rdy_s));

  // ----------------------------------------------------------------
  // State machine
  // ----------------------------------------------------------------
  typedef enum logic [8:0] {
    S_IDLE = 9'h001,
    S_VSETUP = 9'h002,
    S_WLOW = 9'h004,
    S_WHIGH = 9'h008,
    S_RLOW = 9'h010,
    S_RGAP = 9'h020,
    S_VHOLD = 9'h040,
    S_DONE = 9'h080,
    S_WAITRDY = 9'h100
  } fhc_state_e;

  fhc_state_e state_reg;  // Current state
  fhc_req_s req_reg;  // Latched request
  logic [2:0] step_reg;  // Write cycle index
  logic [2:0] nsteps_reg;  // Write cycle index one past the last
  logic [CNT_W-1:0] cnt_reg;  // Phase timer
  logic first_poll_reg;  // No previous status yet
  logic [DATA_W-1:0] last_reg;  // Previous status word
  logic [ADDR_W-1:0] waddr;  // Address of current write cycle
  logic [DATA_W-1:0] wdata;  // Data of current write cycle
  logic [ADDR_W-1:0] prot_addr;  // Protect select address

  // Protect address encoding
  always_comb begin
    prot_addr = req_reg.addr;
    prot_addr[ADDR_BIT_SIX] = (req_reg.op == FHC_OP_UNPROTECT);
    prot_addr[ADDR_BIT_ONE] = 1'b1;
    prot_addr[ADDR_BIT_ZERO] = 1'b0;
  end

  // Command sequence table; bypass skips the unlock pair of a program
  always_comb begin
    waddr = UNLOCK_ADDR1;
    wdata = UNLOCK_DATA1;
    case (step_reg)
      3'h0: begin
        waddr = UNLOCK_ADDR1;
        wdata = UNLOCK_DATA1;
      end
      3'h1: begin
        waddr = UNLOCK_ADDR2;
        wdata = UNLOCK_DATA2;
      end
      3'h2: begin
        waddr = UNLOCK_ADDR1;
        wdata = (req_reg.op == FHC_OP_ERASE) ? CMD_ERASE_SETUP : CMD_PROGRAM;
      end
      3'h3: begin
        waddr = (req_reg.op == FHC_OP_ERASE) ? UNLOCK_ADDR1 : req_reg.addr;
        wdata = (req_reg.op == FHC_OP_ERASE) ? UNLOCK_DATA1 : req_reg.data;
      end
      3'h4: begin
        waddr = UNLOCK_ADDR2;
        wdata = UNLOCK_DATA2;
      end
      3'h5: begin
        waddr = req_reg.addr;
        wdata = CMD_SECTOR_ERASE;
      end
      default: begin
        waddr = prot_addr;
        wdata = CMD_PROTECT;
      end
    endcase
    if (req_reg.bypass && req_reg.op == FHC_OP_PROGRAM) begin
      // Bypass: program code then data only
      waddr = (step_reg == 3'h2) ? UNLOCK_ADDR1 : req_reg.addr;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= S_IDLE;
      req_reg <= '0;
      step_reg <= 3'h0;
      nsteps_reg <= 3'h0;
      cnt_reg <= '0;
      first_poll_reg <= 1'b0;
      last_reg <= '0;
      req_ready <= 1'b0;
      done <= 1'b0;
      rdata <= '0;
      toggle_error <= 1'b0;
      pins <= '{chip_select_n: 1'b1, output_drive_n: 1'b1, write_strobe_n: 1'b1,
                restart_n: 1'b1, high_voltage_en: 1'b0, addr: '0, dout: '0,
                dout_en: 1'b0};
    end else begin
      done <= 1'b0;
      req_ready <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          pins.chip_select_n <= 1'b1;
          pins.dout_en <= 1'b0;
          req_ready <= ~req_valid;
          if (req_valid && req_ready) begin
            req_reg <= req;
            cnt_reg <= '0;
            first_poll_reg <= 1'b1;
            toggle_error <= 1'b0;
            if (req.op == FHC_OP_READ) begin
              step_reg <= 3'h0;
              pins.addr <= req.addr;
              // Select and enable now so the read pulse is full width
              pins.chip_select_n <= 1'b0;
              pins.output_drive_n <= 1'b0;
              state_reg <= S_RLOW;
            end else begin
              case (req.op)
                FHC_OP_PROGRAM: begin
                  step_reg <= req.bypass ? 3'h2 : 3'h0;
                  nsteps_reg <= 3'h4;
                end
                FHC_OP_ERASE: begin
                  step_reg <= 3'h0;
                  nsteps_reg <= 3'h6;
                end
                default: begin
                  step_reg <= 3'h6;
                  nsteps_reg <= 3'h7;
                end
              endcase
              if (req.temp_unprotect) begin
                pins.high_voltage_en <= 1'b1;
                state_reg <= S_VSETUP;
              end else begin
                state_reg <= S_WHIGH;
              end
            end
          end
        end
        S_VSETUP: begin
          // Wait out the high voltage setup before any write
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == CNT_W'(RSP_CYC - 1)) begin
            cnt_reg <= '0;
            state_reg <= S_WHIGH;
          end
        end
        S_WHIGH: begin
          // Address and data stable before strobe falls
          pins.chip_select_n <= 1'b0;
          pins.output_drive_n <= 1'b1;
          pins.write_strobe_n <= 1'b1;
          pins.addr <= waddr;
          pins.dout <= wdata;
          pins.dout_en <= 1'b1;
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == CNT_W'(WE_HIGH_CYC - 1)) begin
            cnt_reg <= '0;
            pins.write_strobe_n <= 1'b0;
            state_reg <= S_WLOW;
          end
        end
        S_WLOW: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == CNT_W'(WE_LOW_CYC - 1)) begin
            cnt_reg <= '0;
            pins.write_strobe_n <= 1'b1;
            if (step_reg + 3'h1 == nsteps_reg) begin
              // Last write cycle: poll status at the valid address
              pins.dout_en <= 1'b0;
              pins.addr <= (req_reg.op == FHC_OP_PROTECT ||
                            req_reg.op == FHC_OP_UNPROTECT) ? prot_addr : req_reg.addr;
              state_reg <= S_RGAP;
            end else begin
              step_reg <= step_reg + 3'h1;
              state_reg <= S_WHIGH;
            end
          end
        end
        S_RGAP: begin
          // Output enable high between polls makes each read new
          pins.output_drive_n <= 1'b1;
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == CNT_W'(RD_GAP_CYC - 1)) begin
            cnt_reg <= '0;
            pins.output_drive_n <= 1'b0;
            state_reg <= S_RLOW;
          end
        end
        S_RLOW: begin
          pins.chip_select_n <= 1'b0;
          pins.output_drive_n <= 1'b0;
          cnt_reg <= cnt_reg + 1'b1;
          // Data passes two sync stages; sample late in the pulse
          if (cnt_reg == CNT_W'(RD_CYC - 1)) begin
            cnt_reg <= '0;
            pins.output_drive_n <= 1'b1;
            last_reg <= din_s;
            first_poll_reg <= 1'b0;
            if (req_reg.op == FHC_OP_READ) begin
              rdata <= din_s;
              state_reg <= S_DONE;
            end else if (!first_poll_reg &&
                         din_s[TOGGLE_BIT] == last_reg[TOGGLE_BIT]) begin
              // Toggle bit stopped: algorithm over, this is array data
              rdata <= din_s;
              // Programmed data should now read true, not complemented
              toggle_error <= (req_reg.op == FHC_OP_PROGRAM) &&
                              (din_s[POLLING_BIT] != req_reg.data[POLLING_BIT]);
              state_reg <= S_WAITRDY;
            end else begin
              state_reg <= S_RGAP;
            end
          end
        end
        S_WAITRDY: begin
          // Ready pin confirms completion before releasing high voltage
          pins.chip_select_n <= 1'b1;
          if (rdy_s) begin
            if (req_reg.temp_unprotect) begin
              cnt_reg <= cnt_reg + 1'b1;
              if (cnt_reg == CNT_W'(RRB_CYC - 1)) begin
                cnt_reg <= '0;
                pins.high_voltage_en <= 1'b0;
                state_reg <= S_VHOLD;
              end
            end else begin
              state_reg <= S_DONE;
            end
          end else begin
            cnt_reg <= '0;
          end
        end
        S_VHOLD: begin
          state_reg <= S_DONE;
        end
        S_DONE: begin
          pins.chip_select_n <= 1'b1;
          pins.output_drive_n <= 1'b1;
          done <= 1'b1;
          state_reg <= S_IDLE;
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end
endmodule : fhc_host

/* verif/fhc_host_checker.sv */
// Port assertions for the flash host controller.
// Bound to fhc_host; one clock domain, async reset.
`timescale 1ns/100ps
module fhc_host_checker
  import fhc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire fhc_req_s req,
  input wire logic req_ready,
  input wire logic done,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic toggle_error,
  input wire fhc_pins_s pins,
  input wire logic [DATA_W-1:0] flash_din,
  input wire logic ready_busy_n
);
  fhc_op_e op_reg;  // Operation in flight
  logic byp_reg;  // Short program form
  logic we_d_reg;  // Strobe one cycle back
  logic [3:0] wr_cnt_reg;  // Write cycles so far
  logic [CNT_W-1:0] hv_cnt_reg;  // Cycles of high voltage
  logic [CNT_W-1:0] rb_cnt_reg;  // Cycles ready has been high
  // ----------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------
  // Capture each accepted request and count its writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      op_reg <= FHC_OP_READ;
      byp_reg <= 1'b0;
      we_d_reg <= 1'b1;
      wr_cnt_reg <= 4'h0;
    end else begin
      we_d_reg <= pins.write_strobe_n;
      if (req_valid && req_ready) begin
        op_reg <= req.op;
        byp_reg <= req.bypass;
        wr_cnt_reg <= 4'h0;
      end else if (we_d_reg && !pins.write_strobe_n) begin
        wr_cnt_reg <= wr_cnt_reg + 4'h1;
      end
    end
  end
  // Window counters; no saturation, idle stretches are short
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hv_cnt_reg <= 16'h0000;
      rb_cnt_reg <= 16'h0000;
    end else begin
      hv_cnt_reg <= pins.high_voltage_en ? hv_cnt_reg + 16'h0001 : 16'h0000;
      rb_cnt_reg <= ready_busy_n ? rb_cnt_reg + 16'h0001 : 16'h0000;
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_we_width: assert property ($fell(pins.write_strobe_n) |->
    !pins.write_strobe_n [*2] ##1 pins.write_strobe_n) else $error("strobe width");
  chk_prog_count: assert property (done && op_reg == FHC_OP_PROGRAM |->
    wr_cnt_reg == (byp_reg ? 4'h2 : 4'h4)) else $error("program write count");
  chk_erase_count: assert property (done && op_reg == FHC_OP_ERASE |->
    wr_cnt_reg == 4'h6) else $error("erase write count");
  chk_prot_count: assert property (done &&
    op_reg inside {FHC_OP_PROTECT, FHC_OP_UNPROTECT} |-> wr_cnt_reg == 4'h1)
    else $error("protect write count");
  chk_prot_addr: assert property ($fell(pins.write_strobe_n) &&
    op_reg inside {FHC_OP_PROTECT, FHC_OP_UNPROTECT} |-> pins.addr[1] && !pins.addr[0] &&
    pins.addr[6] == (op_reg == FHC_OP_UNPROTECT)) else $error("protect address bits");
  chk_hv_setup: assert property ($fell(pins.write_strobe_n) && pins.high_voltage_en |->
    hv_cnt_reg >= RSP_CYC) else $error("high voltage setup short");
  chk_hv_hold: assert property ($fell(pins.high_voltage_en) |->
    rb_cnt_reg >= RRB_CYC) else $error("high voltage hold short");
  chk_done_ready: assert property (done && op_reg != FHC_OP_READ |->
    $past(ready_busy_n, 3)) else $error("done while flash busy");
  chk_poll_width: assert property ($fell(pins.output_drive_n) |->
    !pins.output_drive_n [*4] ##1 pins.output_drive_n) else $error("read pulse width");
  chk_read_clash: assert property (!pins.output_drive_n |-> !pins.dout_en &&
    pins.write_strobe_n && !pins.chip_select_n) else $error("read during drive");
  cover property (done && op_reg == FHC_OP_ERASE);
  cover property (done && byp_reg);
  cover property ($fell(pins.high_voltage_en));
endmodule : fhc_host_checker

bind fhc_host fhc_host_checker chk_u (
  .clk(clk), .rst(rst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
  .done(done), .rdata(rdata), .toggle_error(toggle_error), .pins(pins),
  .flash_din(flash_din), .ready_busy_n(ready_busy_n)
);

/* verif/fhc_flash_model.sv */
// Behavioural parallel NOR flash facing the host controller.
// Assumes strobes held for whole cycles; the model has no clock.
`timescale 1ns/100ps
module fhc_flash_model
  import fhc_pkg::*;
#(
  parameter int BUSY_NS = 2000  // Length of an embedded operation
) (
  input wire fhc_pins_s pins,
  input wire logic bad_prog,
  output logic [DATA_W-1:0] flash_din,
  output logic ready_busy_n
);
  logic [DATA_W-1:0] mem [int];  // Array; absent words read erased
  logic [ADDR_W-1:0] wa_q;  // Latched write address
  logic [DATA_W-1:0] wd_q, prev_d, cmd_d, tgt;  // Write data history
  logic busy = 1'b0, tog = 1'b0, stog = 1'b0, ers = 1'b0;
  initial prev_d = 16'h0000;
  initial flash_din = 16'hA5A5;
  assign ready_busy_n = !busy;
  // Latch the cycle as the strobe falls
  always @(negedge pins.write_strobe_n) begin
    wa_q = pins.addr;
    wd_q = pins.dout;
  end
  // Decode the closing cycle of a command and run the algorithm
  always @(posedge pins.write_strobe_n) begin
    cmd_d = prev_d;
    prev_d = wd_q;
    ers = (cmd_d == UNLOCK_DATA2) && (wd_q == CMD_SECTOR_ERASE);
    if (cmd_d == CMD_PROGRAM || ers || wd_q == CMD_PROTECT) begin
      tgt = ers ? 16'hFFFF : wd_q;
      busy = 1'b1;
      foreach (mem[k]) if (ers && (k >> 12) == (wa_q >> 12)) mem[k] = 16'h0000;
      #(BUSY_NS);
      // Overwrite rather than delete while iterating the array
      foreach (mem[k]) if (ers && (k >> 12) == (wa_q >> 12)) mem[k] = 16'hFFFF;
      // A commanded fault stores a wrong polling bit (bit 7)
      if (cmd_d == CMD_PROGRAM) mem[wa_q] = bad_prog ? wd_q ^ 16'h0080 : wd_q;
      busy = 1'b0;
    end
  end
  // Either strobe starts a fresh read; while busy it flips bit 6, and bit 2 only in the sector being erased
  always @(negedge pins.output_drive_n or negedge pins.chip_select_n) begin
    if (busy) begin
      tog = !tog;
      if (ers && (pins.addr >> 12) == (wa_q >> 12)) stog = !stog;
    end
  end
  // Status while busy, array after; inverted junk when released
  always @(pins or busy or tog or stog) begin
    if (!pins.chip_select_n && !pins.output_drive_n) begin
      if (busy) flash_din = {~tgt[15:7], tog, ~tgt[5:3], stog, ~tgt[1:0]};
      else flash_din = mem.exists(pins.addr) ? mem[pins.addr] : 16'hFFFF;
    end else begin
      flash_din = ~flash_din;
    end
  end
endmodule : fhc_flash_model

/* verif/tb_fhc_host.sv */
// Self-checking bench for the flash host controller.
// Drives user requests; the flash model answers on the pins.
`timescale 1ns/100ps
module tb_fhc_host
  import fhc_pkg::*;
;
  logic clk, rst, req_valid, req_ready, done, toggle_error, ready_busy_n, bad_prog;
  fhc_req_s req;
  logic [DATA_W-1:0] rdata, flash_din;
  fhc_pins_s pins;
  logic [ADDR_W-1:0] wa;  // Address of the last write cycle
  int miscompares = 0, num_checks = 0;
  int nwr = 0, npoll = 0, hvc = 0, rbc = 0, hv_at_wr = 0;  // Pin monitors
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  fhc_host dut_u (.clk(clk), .rst(rst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .done(done), .rdata(rdata), .toggle_error(toggle_error),
    .pins(pins), .flash_din(flash_din), .ready_busy_n(ready_busy_n));
  fhc_flash_model #(.BUSY_NS(2000)) flash_u (.pins(pins), .bad_prog(bad_prog),
    .flash_din(flash_din), .ready_busy_n(ready_busy_n));
  // ----------------------------------------------------------------
  // Pin monitors
  // ----------------------------------------------------------------
  // Count write cycles; note setup time before the first
  always @(negedge pins.write_strobe_n) begin
    nwr = nwr + 1;
    wa = pins.addr;
    if (nwr == 1) hv_at_wr = hvc;
  end
  // Reads issued while the flash reports busy
  always @(negedge pins.output_drive_n) if (!ready_busy_n) npoll = npoll + 1;
  // High voltage cycles, and cycles of it after ready rose
  always @(posedge clk) begin
    hvc <= pins.high_voltage_en ? hvc + 1 : 0;
    rbc <= !ready_busy_n ? 0 : (pins.high_voltage_en ? rbc + 1 : rbc);
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic end_of_test();
    if (miscompares == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test
  // One request, held until taken, then wait for completion
  task automatic run(input fhc_op_e op, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d, input logic byp, input logic tu);
    int n;
    nwr = 0;
    npoll = 0;
    // Ready only rises at an edge that sees valid low
    @(posedge clk);
    #2;
    req = '{op, a, d, byp, tu};
    req_valid = 1'b1;
    for (n = 0; req_ready !== 1'b1 && n < 400; n++) begin
      @(posedge clk);
      #2;
    end
    if (req_ready !== 1'b1) begin
      miscompares++;
      end_of_test();
    end
    @(posedge clk);
    #2;
    req_valid = 1'b0;
    for (n = 0; done !== 1'b1 && n < 20000; n++) begin
      @(posedge clk);
      #2;
    end
    if (done !== 1'b1) begin
      miscompares++;
      end_of_test();
    end
  endtask : run
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    bad_prog = 1'b0;
    req = '0;
    repeat (2) @(posedge clk);
    #2;
    rst = 1'b0;
    check("idle strobe", 1, pins.write_strobe_n);
    check("idle high voltage", 0, pins.high_voltage_en);
    run(FHC_OP_PROGRAM, 22'h00_1234, 16'h5A3C, 1'b0, 1'b0);
    check("program writes", 4, nwr);
    check("polls while busy", 1, npoll > 1);
    check("program result", 16'h5A3C, rdata);
    check("program fault flag", 0, toggle_error);
    run(FHC_OP_PROGRAM, 22'h00_1235, 16'h0F0F, 1'b1, 1'b0);
    check("bypass writes", 2, nwr);
    run(FHC_OP_READ, 22'h00_1235, 16'h0000, 1'b0, 1'b0);
    check("read back", 16'h0F0F, rdata);
    run(FHC_OP_ERASE, 22'h00_1000, 16'h0000, 1'b0, 1'b0);
    check("erase writes", 6, nwr);
    check("erase result", 16'hFFFF, rdata);
    run(FHC_OP_READ, 22'h00_1234, 16'h0000, 1'b0, 1'b0);
    check("erased word", 16'hFFFF, rdata);
    for (int i = 0; i < 2; i++) begin
      run(i ? FHC_OP_UNPROTECT : FHC_OP_PROTECT, 22'h00_3041, 16'h0000, 1'b0, 1'b0);
      check("protect writes", 1, nwr);
      check("protect addr bits", {i[0], 2'b10}, {wa[6], wa[1], wa[0]});
    end
    run(FHC_OP_PROGRAM, 22'h00_2000, 16'h1111, 1'b0, 1'b1);
    check("setup before write", 1, hv_at_wr >= RSP_CYC);
    check("hold after ready", 1, rbc >= RRB_CYC);
    check("high voltage off", 0, pins.high_voltage_en);
    bad_prog = 1'b1;
    run(FHC_OP_PROGRAM, 22'h00_2002, 16'h00C3, 1'b0, 1'b0);
    check("fault flag", 1, toggle_error);
    end_of_test();
  end
endmodule : tb_fhc_host
